//--- blto_pkg.sv
`default_nettype none
package blto_pkg;
  // opcode patterns on the upper bits of the 16-bit instruction word
  localparam logic [3:0] OPC_SKIP_SET = 4'h9;      // 1001 0bbb
  localparam logic [3:0] OPC_BIT_INV = 4'h3;       // 0011 1bbb
  localparam logic [7:0] OPC_LOAD_LIT = 8'hb0;     // 1011 0000
  localparam logic [6:0] OPC_SUB = 7'h02; // 0000 010d
  localparam logic [6:0] OPC_SUB_BORROW = 7'h01; // 0000 001d
  localparam logic [5:0] OPC_LATCH_READ = 6'h28; // 1010 00tx
  // field positions
  localparam int DEST_BIT = 8;
  localparam int BYTE_SEL_BIT = 9;
  localparam int SUB_BIT_MSB = 10;
  localparam int SUB_BIT_LSB = 8;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  typedef enum logic [1:0] {
    BLTO_PH_DECODE = 2'b00,
    BLTO_PH_READ = 2'b01,
    BLTO_PH_PROCESS = 2'b11,
    BLTO_PH_WRITE = 2'b10
  } blto_phase_t;
endpackage : blto_pkg
`default_nettype wire

//--- blto_exec.sv
// Function
// - skip next when tested bit set, flags kept
// - taken skip discards prefetch, runs nop cycle
// - invert one selected bit, single cycle
// - load literal into accumulator, flags kept
// - copy latch byte to file, latch unchanged
// - select one upper byte, zero lower
// - four phases per instruction cycle
// - dest zero to accumulator, one to file
`default_nettype none
module blto_exec
  import blto_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] instr_word,
  output logic instr_take,
  output logic [7:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  input wire logic [15:0] program_table_latch,
  input wire logic carry_in,
  output logic flags_we,
  output logic [3:0] flags_out,
  output logic [7:0] working_accumulator,
  output logic skip_cycle,
  output logic [1:0] phase
);
  blto_phase_t phase_reg;
  blto_phase_t phase_next;
  logic [15:0] ir_reg;
  logic [15:0] ir_next;
  logic [7:0] opnd_reg;
  logic [7:0] opnd_next;
  logic [7:0] res_reg;
  logic [7:0] res_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic flags_we_reg;
  logic flags_we_next;
  logic file_we_reg;
  logic file_we_next;
  logic skip_reg;
  logic skip_next;
  logic skip_pend_reg;
  logic skip_pend_next;

  // four-phase sequencer
  always_comb begin
    unique case (phase_reg)
      BLTO_PH_DECODE: phase_next = BLTO_PH_READ;
      BLTO_PH_READ: phase_next = BLTO_PH_PROCESS;
      BLTO_PH_PROCESS: phase_next = BLTO_PH_WRITE;
      BLTO_PH_WRITE: phase_next = BLTO_PH_DECODE;
    endcase
  end

  wire [15:0] cur = ir_reg;
  wire is_skip = cur[15:12] == OPC_SKIP_SET && !cur[11];
  wire is_inv = cur[15:12] == OPC_BIT_INV && cur[11];
  wire is_lit = cur[15:8] == OPC_LOAD_LIT;
  wire is_sub = cur[15:9] == OPC_SUB;
  wire is_subb = cur[15:9] == OPC_SUB_BORROW;
  wire is_lrd = cur[15:10] == OPC_LATCH_READ;
  wire [2:0] bit_sel = cur[SUB_BIT_MSB:SUB_BIT_LSB];
  wire dest_file = cur[DEST_BIT];
  // one-hot bit mask, one decoder slice per bit position
  wire [7:0] bit_mask;
  for (genvar i = 0; i < 8; i++) begin : gen_mask
    assign bit_mask[i] = bit_sel == 3'(i);
  end

  // subtract as f + ~w + carry; borrow variant uses incoming carry
  wire cin = is_subb ? carry_in : 1'b1;
  wire [8:0] diff = {1'b0, opnd_reg} + {1'b0, ~acc_reg} + {8'h00, cin};
  wire [4:0] dlow = {1'b0, opnd_reg[3:0]} + {1'b0, ~acc_reg[3:0]}
    + {4'h0, cin};
  wire ovf = (opnd_reg[7] != acc_reg[7]) && (diff[7] != opnd_reg[7]);
  wire zero_res = diff[7:0] == 8'h00;
  wire digit_carry = dlow[4];
  wire no_borrow = diff[8]; // carry set means no borrow
  // flag order: overflow, zero, digit carry, carry
  wire [3:0] sub_flags = {ovf, zero_res, digit_carry, no_borrow};
  // byte select from latch
  wire [7:0] latch_byte = cur[BYTE_SEL_BIT] ? program_table_latch[15:8]
    : program_table_latch[7:0];
  wire bit_is_set = |(opnd_reg & bit_mask);

  logic [7:0] res_calc;
  logic wr_file, wr_acc, wr_flags;
  always_comb begin
    res_calc = 8'h00;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    wr_flags = 1'b0;
    if (is_inv) begin
      res_calc = opnd_reg ^ bit_mask;
      wr_file = 1'b1;
    end else if (is_lit) begin
      res_calc = cur[7:0];
      wr_acc = 1'b1;
    end else if (is_sub || is_subb) begin
      res_calc = diff[7:0];
      wr_file = dest_file;
      wr_acc = !dest_file;
      wr_flags = 1'b1;
    end else if (is_lrd) begin
      res_calc = latch_byte;
      wr_file = 1'b1;
    end
  end

  wire in_decode = phase_reg == BLTO_PH_DECODE;
  wire in_read = phase_reg == BLTO_PH_READ;
  wire in_process = phase_reg == BLTO_PH_PROCESS;
  wire in_write = phase_reg == BLTO_PH_WRITE;
  wire take_skip = in_process && is_skip && bit_is_set;

  // a pending skip loads a nop in place of the prefetch
  assign ir_next = in_decode ? (skip_pend_reg ? NOP_WORD : instr_word)
    : ir_reg;
  assign skip_next = in_decode ? skip_pend_reg : skip_reg;
  assign skip_pend_next = take_skip || (skip_pend_reg && !in_decode);
  assign opnd_next = in_read ? file_rdata : opnd_reg;
  assign res_next = in_process ? res_calc : res_reg;
  // accumulator and flags move only when leaving the write phase
  assign acc_next = (in_write && wr_acc) ? res_calc : acc_reg;
  assign flags_next = (in_write && wr_flags) ? sub_flags : flags_reg;
  assign file_we_next = in_write && wr_file;
  assign flags_we_next = in_write && wr_flags;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_reg <= BLTO_PH_DECODE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ir_reg <= NOP_WORD;
    end else begin
      ir_reg <= ir_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      skip_pend_reg <= 1'b0;
    end else begin
      skip_pend_reg <= skip_pend_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      opnd_reg <= DATA_RESET;
    end else begin
      opnd_reg <= opnd_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_reg <= DATA_RESET;
    end else begin
      res_reg <= res_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_reg <= ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_we_reg <= 1'b0;
    end else begin
      flags_we_reg <= flags_we_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      file_we_reg <= 1'b0;
    end else begin
      file_we_reg <= file_we_next;
    end
  end

  // fetch port still fires during the nop so the word is dropped
  assign instr_take = phase_reg == BLTO_PH_DECODE;
  assign file_addr = cur[7:0];
  assign file_we = file_we_reg;
  assign file_wdata = res_reg;
  assign flags_we = flags_we_reg;
  assign flags_out = flags_reg;
  assign working_accumulator = acc_reg;
  assign skip_cycle = skip_reg;
  assign phase = phase_reg;
endmodule : blto_exec
`default_nettype wire

//--- blto_exec_asserts.sv
`default_nettype none
module blto_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic instr_take,
  input wire logic file_we,
  input wire logic flags_we,
  input wire logic [3:0] flags_out,
  input wire logic [7:0] working_accumulator,
  input wire logic skip_cycle,
  input wire logic [1:0] phase
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  phase_seq_a: assert property (phase == 2'b00 |=> phase == 2'b01 ##1
    phase == 2'b11 ##1 phase == 2'b10 ##1 phase == 2'b00) else $error("phase");
  take_slot_a: assert property (instr_take == (phase == 2'b00))
    else $error("take");
  write_slot_a: assert property (file_we |-> $past(phase) == 2'b10)
    else $error("write slot");
  flag_pulse_a: assert property (flags_we |=> !flags_we [*3])
    else $error("flags pulse");
  skip_len_a: assert property ($rose(skip_cycle) |-> phase == 2'b01
    ##0 skip_cycle [*4] ##1 !skip_cycle) else $error("skip length");
  skip_quiet_a: assert property (skip_cycle |-> !file_we && !flags_we)
    else $error("skip wrote");
  acc_slot_a: assert property (!$stable(working_accumulator)
    |-> $past(phase) == 2'b10 || $past(srst)) else $error("acc slot");
  skip_acc_a: assert property (skip_cycle |=>
    $stable(working_accumulator)) else $error("acc in nop");
  flags_stay_a: assert property (!$stable(flags_out) |-> flags_we)
    else $error("flags moved");
endmodule : blto_chk
bind blto_exec blto_chk blto_chk_inst (.core_clk, .srst, .instr_take,
  .file_we, .flags_we, .flags_out, .working_accumulator, .skip_cycle,
  .phase);
`default_nettype wire

//--- blto_exec_tb.sv
`default_nettype none
module blto_exec_tb
  import blto_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, cin = 0, pend = 0;
  logic [15:0] iw = 0, ltch = 0;
  logic [7:0] rd = 0, a = ACC_RESET;
  logic [3:0] fk = FLAGS_RESET;
  wire fwe, flwe, skp, tk;
  wire [1:0] ph;
  wire [7:0] wd, acc, fa;
  wire [3:0] fl;
  int num_errors = 0, check_count = 0;
  always #20 core_clk = ~core_clk;
  blto_exec blto_exec_inst (.core_clk, .srst, .instr_word(iw), .phase(ph),
    .instr_take(tk), .file_addr(fa), .file_rdata(rd), .file_we(fwe),
    .file_wdata(wd), .program_table_latch(ltch), .carry_in(cin),
    .flags_we(flwe), .flags_out(fl), .working_accumulator(acc),
    .skip_cycle(skp));
  function automatic logic [1:0] phase_after(input int k);
    return k == 0 ? BLTO_PH_READ : k == 1 ? BLTO_PH_PROCESS
      : k == 2 ? BLTO_PH_WRITE : BLTO_PH_DECODE;
  endfunction : phase_after
  task automatic check_value(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", name, exp, seen);
    end
  endtask : check_value
  task automatic op(input logic [15:0] w);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] r, ea;
    logic we, fw, sk, p, s;
    r = 8'h00;
    {we, fw, sk} = 3'b000;
    p = pend;
    ea = p ? NOP_WORD[7:0] : w[7:0];
    {rd, ltch, cin} = 25'($urandom);
    iw = w;
    if (!p) begin
      if (w[15:12] == OPC_SKIP_SET && !w[11]) sk = rd[w[10:8]];
      else if (w[15:12] == OPC_BIT_INV && w[11]) begin
        we = 1;
        r = rd ^ (8'h01 << w[10:8]);
      end else if (w[15:8] == OPC_LOAD_LIT) a = w[7:0];
      else if (w[15:10] == OPC_LATCH_READ) begin
        we = 1;
        r = w[9] ? ltch[15:8] : ltch[7:0];
      end else if (w[15:9] == OPC_SUB || w[15:9] == OPC_SUB_BORROW) begin
        s = w[15:9] == OPC_SUB || cin;
        t = {1'b0, rd} + {1'b0, ~a} + {8'h00, s};
        h = {1'b0, rd[3:0]} + {1'b0, ~a[3:0]} + {4'h0, s};
        fw = 1;
        fk = {rd[7] != a[7] && t[7] != rd[7], t[7:0] == 0, h[4], t[8]};
        if (w[8]) {we, r} = {1'b1, t[7:0]};
        else a = t[7:0];
      end
    end
    pend = sk;
    for (int k = 0; k < 4; k++) begin
      @(negedge core_clk);
      check_value("phase", 16'(ph), 16'(phase_after(k)));
      check_value("instr_take", 16'(tk), 16'(k == 3));
    end
    check_value("skip_cycle", 16'(skp), 16'(p));
    check_value("file_we", 16'(fwe), 16'(we));
    if (we) check_value("file_wdata", 16'(wd), 16'(r));
    check_value("file_addr", 16'(fa), 16'(ea));
    check_value("flags_we", 16'(flwe), 16'(fw));
    check_value("flags_out", 16'(fl), 16'(fk));
    check_value("accumulator", 16'(acc), 16'(a));
  endtask : op
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #41600;
    num_errors++;
    stop_test();
  end
  initial begin
    logic [15:0] v;
    void'($urandom(32'h236a));
    repeat (8) @(negedge core_clk);
    srst = 0;
    op({OPC_LOAD_LIT, 8'hff});
    op({OPC_SUB, 9'h000});
    repeat (200) begin
      v = 16'($urandom);
      case ($urandom_range(5))
        0: op({OPC_SKIP_SET, 1'b0, v[10:0]});
        1: op({OPC_BIT_INV, 1'b1, v[10:0]});
        2: op({OPC_LOAD_LIT, v[7:0]});
        3: op({OPC_SUB, v[8:0]});
        4: op({OPC_SUB_BORROW, v[8:0]});
        default: op({OPC_LATCH_READ, v[9:0]});
      endcase
    end
    // second reset mid-run: state and any pending skip must clear
    srst = 1;
    repeat (2) @(negedge core_clk);
    srst = 0;
    {a, fk, pend} = {ACC_RESET, FLAGS_RESET, 1'b0};
    op({OPC_LATCH_READ, 10'h25a});
    stop_test();
  end
endmodule : blto_exec_tb
`default_nettype wire
